// [pkg/stap_pkg.sv]
// Constants and types for the SRAM test access port logic
package stap_pkg;
  // Instruction register width and codes
  localparam int          IR_W          = 3;
  localparam logic [2:0]  OP_EXTERNAL   = 3'h0;
  localparam logic [2:0]  OP_IDENT      = 3'h1;
  localparam logic [2:0]  OP_SAMPLE_Z   = 3'h2;
  localparam logic [2:0]  OP_RESERVED_A = 3'h3;
  localparam logic [2:0]  OP_SAMPLE     = 3'h4;
  localparam logic [2:0]  OP_PRIVATE    = 3'h5;
  localparam logic [2:0]  OP_RESERVED_B = 3'h6;
  localparam logic [2:0]  OP_BYPASS     = 3'h7;
  // Capture-IR fixed pattern in the two low bits
  localparam logic [1:0]  IR_CAPTURE    = 2'h1;
  // Identification register
  localparam int          ID_W          = 32;
  // Five TMS-high edges reach reset from any state
  localparam int          RESET_TMS_EDGES = 5;

  // Controller states
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
    ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } stap_state_t;

  // Data register selection
  typedef enum logic [1:0] {
    SEL_BYPASS, SEL_BOUNDARY, SEL_IDENT
  } stap_sel_t;
endpackage

// [core/stap_core.sv]
// Test access port controller, instruction decode and data registers
`timescale 1ns/100ps
module stap_core #(
  parameter int                 BSR_W     = 16,          // Boundary length
  parameter logic [BSR_W-1:0]   PIN_MASK  = {BSR_W{1'b1}}, // 1 = has a pin
  parameter logic [BSR_W-1:0]   CELL_DFLT = {BSR_W{1'b1}}, // Pinless value
  parameter logic [31:0]        ID_CODE   = 32'h0000_0001  // Arbitrary value
) (
  // System clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // Test port pins, asynchronous to ref_clk
  input  wire logic             tck,
  input  wire logic             tms,
  input  wire logic             tdi,
  output logic                  tdo,
  output logic                  tdo_oe,
  // RAM pad ring: sampled levels and scan-driven outputs
  input  wire logic [BSR_W-1:0] pad_level,
  output logic      [BSR_W-1:0] pad_scan_value,
  output logic                  pad_scan_drive,
  output logic                  pad_force_hiz
);
  import stap_pkg::*;

  // Whole module state in one record
  typedef struct packed {
    logic [1:0]        tck_s;     // Two-stage synchroniser of tck
    logic [1:0]        tms_s;     // Synchroniser of tms
    logic [1:0]        tdi_s;     // Synchroniser of tdi
    logic              tck_d;     // Previous synced tck, for edges
    stap_state_t       state;     // Controller state
    logic [2:0]        ir_shift;  // Instruction shift stage
    logic [2:0]        ir;        // Current instruction
    logic              bypass;    // Bypass cell
    logic [31:0]       ident;     // Identification register
    logic [BSR_W-1:0]  bsr;       // Boundary shift stage
    logic [BSR_W-1:0]  bsr_upd;   // Boundary update latch
    logic              drive;     // Outputs driven from boundary
    logic              tdo;       // Serial out, updated on fall
    logic              tdo_oe;    // Serial out enable
  } stap_st_t;

  stap_st_t st_reg;
  stap_st_t st_next;

  // Decode an instruction to its data register
  function automatic stap_sel_t sel_of(input logic [2:0] op);
    unique case (op)
      OP_EXTERNAL, OP_SAMPLE, OP_SAMPLE_Z : sel_of = SEL_BOUNDARY;
      OP_IDENT                            : sel_of = SEL_IDENT;
      // Reserved, private and bypass all take the bypass cell
      default                             : sel_of = SEL_BYPASS;
    endcase
  endfunction

  // Next controller state from TMS
  function automatic stap_state_t step(input stap_state_t s, input logic m);
    unique case (s)
      ST_RESET    : step = m ? ST_RESET    : ST_IDLE;
      ST_IDLE     : step = m ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR   : step = m ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR   : step = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR : step = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR : step = m ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR : step = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR : step = m ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR   : step = m ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR   : step = m ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR   : step = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR : step = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR : step = m ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR : step = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR : step = m ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR   : step = m ? ST_SEL_DR   : ST_IDLE;
    endcase
  endfunction

  // Edge flags of the synchronised test clock
  logic      tck_rise;
  logic      tck_fall;
  stap_sel_t cur_sel;
  logic      serial_bit;

  // Edges read only the second stage and its delayed copy
  assign tck_rise = st_reg.tck_s[1] & ~st_reg.tck_d;
  assign tck_fall = ~st_reg.tck_s[1] & st_reg.tck_d;
  assign cur_sel  = sel_of(st_reg.ir);

  // Bit that leaves the selected register on the next fall
  always_comb begin
    if (st_reg.state == ST_SHIFT_IR) begin
      serial_bit = st_reg.ir_shift[0];
    end else begin
      unique case (cur_sel)
        SEL_BOUNDARY : serial_bit = st_reg.bsr[0];
        SEL_IDENT    : serial_bit = st_reg.ident[0];
        default      : serial_bit = st_reg.bypass;
      endcase
    end
  end

  // Next-state logic for the whole record
  always_comb begin
    st_next       = st_reg;
    // Test port pins pass two flops before any logic reads them
    st_next.tck_s = {st_reg.tck_s[0], tck};
    st_next.tms_s = {st_reg.tms_s[0], tms};
    st_next.tdi_s = {st_reg.tdi_s[0], tdi};
    st_next.tck_d = st_reg.tck_s[1];

    // Rising edge: sample TMS/TDI, capture and shift
    if (tck_rise) begin
      // Held TMS high walks every path to reset in five
      st_next.state = step(st_reg.state, st_reg.tms_s[1]);
      unique case (st_reg.state)
        ST_CAP_IR : begin
          st_next.ir_shift = {st_reg.ir[2], IR_CAPTURE};
        end
        ST_SHIFT_IR : begin
          st_next.ir_shift = {st_reg.tdi_s[1], st_reg.ir_shift[2:1]};
        end
        ST_CAP_DR : begin
          unique case (cur_sel)
            // Pinless cells take defaults; pins give levels
            SEL_BOUNDARY : st_next.bsr = (pad_level & PIN_MASK)
                                       | (CELL_DFLT & ~PIN_MASK);
            SEL_IDENT    : st_next.ident = ID_CODE;
            default      : st_next.bypass = 1'b0;
          endcase
        end
        ST_SHIFT_DR : begin
          unique case (cur_sel)
            SEL_BOUNDARY : st_next.bsr =
              {st_reg.tdi_s[1], st_reg.bsr[BSR_W-1:1]};
            SEL_IDENT    : st_next.ident =
              {st_reg.tdi_s[1], st_reg.ident[31:1]};
            default      : st_next.bypass = st_reg.tdi_s[1];
          endcase
        end
        default : begin
        end
      endcase
    end

    // Falling edge: present serial out and apply updates
    if (tck_fall) begin
      st_next.tdo    = serial_bit;
      // Entering Test-Logic-Reset restores ident at the next fall,
      // so pad controls still move only on falling test clock
      if (st_reg.state == ST_RESET) begin
        st_next.ir    = OP_IDENT;
        st_next.drive = 1'b0;
      end
      // Output enabled only while shifting
      st_next.tdo_oe = (st_reg.state == ST_SHIFT_DR)
                     | (st_reg.state == ST_SHIFT_IR);
      if (st_reg.state == ST_UPD_IR) begin
        // New code takes effect only here
        st_next.ir    = st_reg.ir_shift;
        // External test drives the latched pattern out
        st_next.drive = (st_reg.ir_shift == OP_EXTERNAL);
        st_next.bsr_upd = st_reg.bsr;
      end
      if (st_reg.state == ST_UPD_DR && cur_sel == SEL_BOUNDARY) begin
        st_next.bsr_upd = st_reg.bsr;
      end
    end

    // Power-up reset: also the Test-Logic-Reset state
    if (reset) begin
      st_next          = '0;
      st_next.state    = ST_RESET;
      st_next.ir       = OP_IDENT;
      st_next.bypass   = 1'b0;
    end
  end

  // Register the record
  always_ff @(posedge ref_clk) begin
    st_reg <= st_next;
  end

  // Pin outputs; RAM inputs are never blocked here
  assign tdo            = st_reg.tdo;
  assign tdo_oe         = st_reg.tdo_oe;
  assign pad_scan_value = st_reg.bsr_upd;
  assign pad_scan_drive = st_reg.drive;
  assign pad_force_hiz  = (st_reg.ir == OP_SAMPLE_Z);

endmodule // stap_core

// [test/stap_properties.sv]
// Port checks for the test access port core
`timescale 1ns/100ps
module stap_properties #(parameter int BSR_W = 16) (
  // Clock, reset and scan pins
  input wire logic             ref_clk,
  input wire logic             reset,
  input wire logic             tck,
  input wire logic             tms,
  input wire logic             tdo,
  input wire logic             tdo_oe,
  // Pad ring controls
  input wire logic [BSR_W-1:0] pad_scan_value,
  input wire logic             pad_scan_drive,
  input wire logic             pad_force_hiz
);
  logic       tck_q;  // Last test clock sample
  logic [2:0] hi_cnt; // Rises seen with mode high, saturates at 5
  // Count test clock rises with mode select held high
  always_ff @(posedge ref_clk) begin
    tck_q <= tck;
    if (reset)
      hi_cnt <= 3'h0;
    else if (tck && !tck_q)
      hi_cnt <= !tms ? 3'h0 : (hi_cnt == 3'h5 ? hi_cnt : hi_cnt + 3'h1);
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !tdo_oe
    && !pad_scan_drive && !pad_force_hiz) else $error("reset lost");
  a_oe_on_fall: assert property ($changed(tdo_oe) |-> !$past(tck))
    else $error("tdo_oe moved off falling clock");
  a_tdo_on_fall: assert property ($changed(tdo) |-> !$past(tck))
    else $error("tdo moved off falling clock");
  a_pad_modes_excl: assert property (!(pad_scan_drive && pad_force_hiz))
    else $error("drive and float together");
  a_drive_on_fall: assert property ($changed(pad_scan_drive) |-> !$past(tck))
    else $error("drive moved off falling clock");
  a_hiz_on_fall: assert property ($rose(pad_force_hiz) |-> $past(!tck, 1))
    else $error("float rose off falling clock");
  a_value_hold: assert property (tck && $past(tck) |-> $stable(pad_scan_value))
    else $error("pad value moved while clock high");
  a_tms_reset: assert property ($rose(hi_cnt == 3'h5) |-> ##[1:12]
    !(pad_scan_drive || pad_force_hiz)) else $error("no tms reset");
  cover property ($rose(pad_scan_drive));
  cover property ($rose(pad_force_hiz));
  cover property ($rose(hi_cnt == 3'h5));
endmodule // stap_properties
bind stap_core stap_properties #(.BSR_W(BSR_W)) stap_properties_inst (
  .ref_clk, .reset, .tck, .tms, .tdo, .tdo_oe, .pad_scan_value,
  .pad_scan_drive, .pad_force_hiz);

// [test/stap_host.sv]
// Scan controller model driving the test pins
`timescale 1ns/100ps
module stap_host (
  // Clock and scan pins
  input  wire logic ref_clk,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  wire line = tdo_oe ? tdo : 1'bz; // Released output floats
  initial begin
    tck = 1'b0; // Clock stands still between frames
    tms = 1'b1; // Idles high like an undriven pin
    tdi = 1'b1;
  end
  // One 8-cycle period: change at fall, read mid-high, hold 4 each side
  task automatic step(input logic m, input logic d, output logic s);
    @(posedge ref_clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge ref_clk);
    tck <= 1'b1;
    repeat (2) @(posedge ref_clk);
    s = line;
    @(posedge ref_clk);
  endtask
  // Walk the state machine with mode bits, LSB first
  task automatic go(input logic [4:0] m, input int n);
    logic s;
    for (int i = 0; i < n; i++) step(m[i], 1'b1, s);
  endtask
  // Shift n bits, last with mode high to leave shift
  task automatic shift(input logic [31:0] d, input int n,
      output logic [31:0] q);
    q = '0;
    for (int i = 0; i < n; i++) step(i == n - 1, d[i], q[i]);
  endtask
  // Idle to idle through the instruction path
  task automatic load_ir(input logic [2:0] c, output logic [31:0] q);
    go(5'h03, 4);
    shift({29'h0, c}, 3, q);
    go(5'h01, 2);
  endtask
  // Idle to idle through the data path
  task automatic scan_dr(input logic [31:0] d, input int n,
      output logic [31:0] q);
    go(5'h01, 3);
    shift(d, n, q);
    go(5'h01, 2);
  endtask
endmodule // stap_host

// [test/tb.sv]
// Self-checking bench for the test access port core
`timescale 1ns/100ps
module tb;
  import stap_pkg::*;
  localparam logic [31:0] ID_VAL = 32'h1357_9BDF; // Arbitrary value
  localparam logic [15:0] MASK   = 16'h7FFF;      // Top cell has no pin
  localparam logic [15:0] DFLT   = 16'h8000;      // Fixed level, unlike pads
  logic        ref_clk   = 1'b0;
  logic        reset     = 1'b1;
  logic [15:0] pad_level = 16'h0000;
  logic        tck, tms, tdi, tdo, tdo_oe, pad_scan_drive, pad_force_hiz;
  logic [15:0] pad_scan_value;
  logic [31:0] q;
  int          fails     = 0;
  int          n_tests   = 0;
  logic [2:0]  codes [4] = '{OP_RESERVED_A, OP_PRIVATE, OP_RESERVED_B,
                             OP_BYPASS};
  stap_core #(.BSR_W(16), .PIN_MASK(MASK), .CELL_DFLT(DFLT),
    .ID_CODE(ID_VAL)) stap_core_inst (.ref_clk, .reset, .tck, .tms, .tdi,
    .tdo, .tdo_oe, .pad_level, .pad_scan_value, .pad_scan_drive,
    .pad_force_hiz);
  stap_host stap_host_inst (.ref_clk, .tck, .tms, .tdi, .tdo, .tdo_oe);
  initial forever #50 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Identification read straight out of reset
  task automatic t_ident;
    stap_host_inst.go(5'h00, 1);
    stap_host_inst.scan_dr(32'h0, 32, q);
    chk("idcode", q, ID_VAL);
  endtask
  // Reserved, private and bypass codes give a one-bit path
  task automatic t_bypass;
    foreach (codes[i]) begin
      stap_host_inst.load_ir(codes[i], q);
      chk("ir_capture", q[1:0], 2'h1);
      chk("tdo_oe_idle", tdo_oe, 1'b0);
      stap_host_inst.scan_dr(32'h5, 3, q);
      chk("bypass", q[2:0], 3'h2);
    end
  endtask
  // Sample then preload, then external test drives the pattern
  task automatic t_sample_extest;
    @(posedge ref_clk) pad_level <= 16'hA5C3;
    stap_host_inst.load_ir(OP_SAMPLE, q);
    stap_host_inst.scan_dr(32'h3C5A, 16, q);
    chk("sample", q[15:0], 16'hA5C3 & MASK | DFLT & ~MASK);
    chk("drive_off", pad_scan_drive, 1'b0);
    stap_host_inst.load_ir(OP_EXTERNAL, q);
    chk("drive_on", pad_scan_drive, 1'b1);
    chk("drive_value", pad_scan_value, 16'h3C5A);
    @(posedge ref_clk) pad_level <= 16'h5A0F;
    stap_host_inst.scan_dr(32'hFFFF, 16, q);
    chk("extest_cap", q[15:0], 16'h5A0F & MASK | DFLT & ~MASK);
    chk("extest_out", pad_scan_value, 16'hFFFF);
  endtask
  // Float instruction, then five mode-high clocks restore identification
  task automatic t_sample_z;
    stap_host_inst.load_ir(OP_SAMPLE_Z, q);
    chk("hiz_on", {pad_force_hiz, pad_scan_drive}, 2'h2);
    stap_host_inst.scan_dr(32'h0, 16, q);
    chk("hiz_cap", q[15:0], 16'h5A0F & MASK | DFLT & ~MASK);
    stap_host_inst.go(5'h1F, 5);
    stap_host_inst.go(5'h00, 1);
    chk("hiz_off", pad_force_hiz, 1'b0);
    stap_host_inst.scan_dr(32'h0, 32, q);
    chk("idcode_again", q, ID_VAL);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    t_ident();
    t_bypass();
    t_sample_extest();
    t_sample_z();
    stop_test();
  end
  // Cut a hang short
  initial begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    stop_test();
  end
endmodule // tb
